// *** core/sew_map.vh ***
// Purpose: constants for the two-wire eeprom slave
// Assumes: core_clk at 40 MHz
// Notes: timing counts derived from printed times
`ifndef SEW_MAP_VH
`define SEW_MAP_VH
`define SEW_CLK_MHZ 40
`define SEW_TYPE_CODE 4'hA
`define SEW_WR_TIME_MS 5
`define SEW_WR_CYCLES (`SEW_WR_TIME_MS * 1000 * `SEW_CLK_MHZ)
`define SEW_DEV_BIT_MSB 7
`define SEW_DEV_BIT_LSB 4
`define SEW_RW_BIT 0
`endif

// *** core/sew_sync.v ***
// Purpose: two flip-flop synchroniser for one pin
// Assumes: single clock domain core_clk
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module sew_sync (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // pin in, synchronised level out
  input wire pinIn,
  output reg pinSync
);
  reg stage1_r;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1_r <= 1'b1;
      pinSync <= 1'b1;
    end else begin
      stage1_r <= pinIn;
      pinSync <= stage1_r;
    end
  end
endmodule
`default_nettype wire

// *** core/sew_eeprom_slave.v ***
// Purpose: slave protocol engine of a small two-wire serial eeprom
// Assumes: SCL and SDA are pins outside core_clk, sampled by two flip-flops
// Notes: DENSITY_KBIT picks 1,2,4,8 or 16; memory is a plain array, no retention model
`timescale 1ns/1ps
`default_nettype none
`include "sew_map.vh"
module sew_eeprom_slave #(
  parameter DENSITY_KBIT = 2,
  parameter WR_CYCLES = `SEW_WR_CYCLES
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // two-wire bus
  input wire sclIn,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe_n,
  // straps
  input wire strap_pin_high,
  input wire strap_pin_mid,
  input wire strap_pin_low,
  // status
  output reg writeBusy
);
  localparam AW = (DENSITY_KBIT == 1) ? 7 : (DENSITY_KBIT == 2) ? 8 :
    (DENSITY_KBIT == 4) ? 9 : (DENSITY_KBIT == 8) ? 10 : 11;
  localparam PAGE_BITS = (DENSITY_KBIT <= 2) ? 3 : 4;
  localparam PAGE_BYTES = 1 << PAGE_BITS;
  localparam NPG = (DENSITY_KBIT == 4) ? 1 : (DENSITY_KBIT == 8) ? 2 : (DENSITY_KBIT == 16) ? 3 : 0;
  localparam MEM_WORDS = 1 << AW;
  localparam CW = 23;
  localparam [CW-1:0] WR_LAST = WR_CYCLES - 1;

  localparam ST_IDLE = 3'd0;
  localparam ST_DEV = 3'd1;
  localparam ST_WADDR = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_RDATA = 3'd4;
  localparam ST_MACK = 3'd5;

  wire sclS;
  wire sdaS;
  sew_sync uSyncScl (.core_clk(core_clk), .rst(rst), .pinIn(sclIn), .pinSync(sclS));
  sew_sync uSyncSda (.core_clk(core_clk), .rst(rst), .pinIn(sdaIn), .pinSync(sdaS));

  reg sclD_r;
  reg sdaD_r;
  reg [2:0] state_r;
  reg [3:0] bitCnt_r;
  reg [7:0] shift_r;
  reg [AW-1:0] addr_r;
  reg [2:0] pageHi_r;
  reg wrPend_r;
  reg [PAGE_BITS:0] bufCnt_r;
  reg [CW-1:0] wrTimer_r;
  reg [PAGE_BITS-1:0] bufLo_r;
  reg [7:0] rdByte_r;
  reg [7:0] mem [0:MEM_WORDS-1];
  reg [7:0] pageBuf [0:PAGE_BYTES-1];
  reg [PAGE_BYTES-1:0] bufValid_r;
  reg [AW-1:0] pageBase_r;

  wire sclRise = sclS & ~sclD_r;
  wire sclFall = ~sclS & sclD_r;
  wire startCond = sclS & sclD_r & sdaD_r & ~sdaS;
  wire stopCond = sclS & sclD_r & ~sdaD_r & sdaS;
  // page bits above the received word address; cut to the array width where used
  wire [10:0] wordFull = {pageHi_r, shift_r};

  // strap compare; page bits occupy the low straps' positions
  function devMatch;
    input [7:0] w;
    reg [2:0] straps;
    reg [2:0] mask;
    begin
      straps = {strap_pin_high, strap_pin_mid, strap_pin_low};
      mask = (NPG == 0) ? 3'h7 : (NPG == 1) ? 3'h6 : (NPG == 2) ? 3'h4 : 3'h0;
      devMatch = (w[`SEW_DEV_BIT_MSB:`SEW_DEV_BIT_LSB] == `SEW_TYPE_CODE) &&
        (((w[3:1] ^ straps) & mask) == 3'h0);
    end
  endfunction

  // sequential address advance over the whole array
  function [AW-1:0] nextAddr;
    input [AW-1:0] a;
    begin
      nextAddr = a + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  integer i;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
      state_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      addr_r <= {AW{1'b0}};
      pageHi_r <= 3'h0;
      wrPend_r <= 1'b0;
      bufCnt_r <= {(PAGE_BITS+1){1'b0}};
      wrTimer_r <= {CW{1'b0}};
      bufLo_r <= {PAGE_BITS{1'b0}};
      rdByte_r <= 8'h00;
      bufValid_r <= {PAGE_BYTES{1'b0}};
      pageBase_r <= {AW{1'b0}};
      sdaOut <= 1'b1;
      sdaOe_n <= 1'b1;
      writeBusy <= 1'b0;
    end else begin
      sclD_r <= sclS;
      sdaD_r <= sdaS;
      if (writeBusy) begin
        // bus ignored while storing; sda stays released, so polls see no ack
        sdaOe_n <= 1'b1;
        sdaOut <= 1'b1;
        state_r <= ST_IDLE;
        if (wrTimer_r == WR_LAST) begin
          writeBusy <= 1'b0;
          for (i = 0; i < PAGE_BYTES; i = i + 1) begin
            if (bufValid_r[i]) begin
              mem[pageBase_r | i[AW-1:0]] <= pageBuf[i];
            end
          end
          bufValid_r <= {PAGE_BYTES{1'b0}};
        end else begin
          wrTimer_r <= wrTimer_r + {{(CW-1){1'b0}}, 1'b1};
        end
      end else if (stopCond) begin
        state_r <= ST_IDLE;
        sdaOe_n <= 1'b1;
        sdaOut <= 1'b1;
        if (wrPend_r) begin
          writeBusy <= 1'b1;
          wrTimer_r <= {CW{1'b0}};
          wrPend_r <= 1'b0;
        end
      end else if (startCond) begin
        // repeated start also commits a pending byte set and begins the write
        state_r <= ST_DEV;
        // the scl fall that closes the start is not a data bit; it wraps the count to zero
        bitCnt_r <= 4'hF;
        sdaOe_n <= 1'b1;
        sdaOut <= 1'b1;
        if (wrPend_r) begin
          writeBusy <= 1'b1;
          wrTimer_r <= {CW{1'b0}};
          wrPend_r <= 1'b0;
        end
      end else if (sclRise) begin
        if (bitCnt_r < 4'd8) begin
          shift_r <= {shift_r[6:0], sdaS};
        end
        if (state_r == ST_MACK && bitCnt_r == 4'd8) begin
          if (sdaS) begin
            state_r <= ST_IDLE;
          end else begin
            // next byte is launched on the coming scl fall
            rdByte_r <= mem[addr_r];
            addr_r <= nextAddr(addr_r);
          end
        end
      end else if (sclFall) begin
        case (state_r)
          ST_IDLE: begin
            sdaOe_n <= 1'b1;
          end
          ST_DEV, ST_WADDR, ST_WDATA: begin
            if (bitCnt_r == 4'd7) begin
              bitCnt_r <= 4'd8;
              if (state_r == ST_DEV && !devMatch(shift_r)) begin
                state_r <= ST_IDLE;
              end else begin
                sdaOut <= 1'b0;
                sdaOe_n <= 1'b0;
                if (state_r == ST_DEV) begin
                  pageHi_r <= shift_r[3:1];
                end else if (state_r == ST_WADDR) begin
                  addr_r <= wordFull[AW-1:0];
                  pageBase_r <= {wordFull[AW-1:PAGE_BITS], {PAGE_BITS{1'b0}}};
                  bufLo_r <= shift_r[PAGE_BITS-1:0];
                  bufValid_r <= {PAGE_BYTES{1'b0}};
                end else begin
                  pageBuf[bufLo_r] <= shift_r;
                  bufValid_r[bufLo_r] <= 1'b1;
                  bufLo_r <= bufLo_r + {{(PAGE_BITS-1){1'b0}}, 1'b1};
                  addr_r <= {addr_r[AW-1:PAGE_BITS], bufLo_r + {{(PAGE_BITS-1){1'b0}}, 1'b1}};
                  wrPend_r <= 1'b1;
                end
              end
            end else if (bitCnt_r == 4'd8) begin
              bitCnt_r <= 4'h0;
              sdaOe_n <= 1'b1;
              sdaOut <= 1'b1;
              if (state_r == ST_DEV) begin
                if (shift_r[`SEW_RW_BIT]) begin
                  state_r <= ST_RDATA;
                  sdaOut <= mem[addr_r][7];
                  sdaOe_n <= mem[addr_r][7];
                  rdByte_r <= mem[addr_r];
                  addr_r <= nextAddr(addr_r);
                end else begin
                  state_r <= ST_WADDR;
                end
              end else begin
                state_r <= ST_WDATA;
              end
            end else begin
              bitCnt_r <= bitCnt_r + 4'h1;
            end
          end
          ST_RDATA: begin
            if (bitCnt_r == 4'd7) begin
              bitCnt_r <= 4'd8;
              sdaOut <= 1'b1;
              sdaOe_n <= 1'b1;
              state_r <= ST_MACK;
            end else begin
              bitCnt_r <= bitCnt_r + 4'h1;
              sdaOut <= rdByte_r[3'd6 - bitCnt_r[2:0]];
              sdaOe_n <= rdByte_r[3'd6 - bitCnt_r[2:0]];
            end
          end
          ST_MACK: begin
            state_r <= ST_RDATA;
            bitCnt_r <= 4'h0;
            sdaOut <= rdByte_r[7];
            sdaOe_n <= rdByte_r[7];
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/sew_assertions.sv ***
// Purpose: bus checks for the eeprom slave
// Assumes: sees only the slave's ports
// Notes: raw scl leads the slave's synced view
`timescale 1ns/1ps
`default_nettype none
module sew_assertions #(
  parameter WR_CYCLES = 2000
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // bus and status
  input wire sclIn,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOe_n,
  input wire writeBusy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  int busyCnt;
  always @(posedge core_clk or posedge rst)
    if (rst)
      busyCnt <= 0;
    else
      busyCnt <= writeBusy ? busyCnt + 1 : 0;
  a_drive_low: assert property (!sdaOe_n |-> !sdaOut)
    else $error("sda driven high");
  a_change_scl_low: assert property ($changed(sdaOe_n) |-> !sclIn)
    else $error("sda moved with scl high");
  a_drive_stands: assert property (!sdaOe_n && sclIn |=> !sdaOe_n || !sclIn)
    else $error("sda dropped with scl high");
  a_start_quiet: assert property ($fell(sdaIn) && sclIn |=> sdaOe_n [*8])
    else $error("drive right after start");
  a_stop_quiet: assert property ($rose(sdaIn) && sclIn |=> sdaOe_n [*8])
    else $error("drive right after stop");
  a_busy_stop: assert property ($rose(writeBusy) |-> sclIn && $past(sclIn, 3))
    else $error("write began off a stop");
  a_busy_quiet: assert property (writeBusy |-> sdaOe_n)
    else $error("answer during write");
  a_busy_len: assert property ($fell(writeBusy) |-> busyCnt inside {[WR_CYCLES-8:WR_CYCLES+2]})
    else $error("write time wrong");
  c_write: cover property ($rose(writeBusy));
  c_ack: cover property ($fell(sdaOe_n));
  c_done: cover property ($fell(writeBusy));
endmodule
bind sew_eeprom_slave sew_assertions #(.WR_CYCLES(WR_CYCLES)) chk (.core_clk(core_clk), .rst(rst),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .writeBusy(writeBusy));
`default_nettype wire

// *** tb/sew_master.sv ***
// Purpose: two-wire bus master model
// Assumes: pull-up on sda, open-drain drive
// Notes: slow scl covers the slave's sync latency
`timescale 1ns/1ps
`default_nettype none
module sew_master (
  // bus
  output logic scl,
  output logic sdaDrv_n,
  input wire logic sda
);
  // quarter of the 200 ns scl period; started on a core_clk fall, every step stays on one
  localparam int Q = 50;
  initial begin
    scl = 1;
    sdaDrv_n = 1;
  end
  task automatic bitOut(input logic b);
    sdaDrv_n = b;
    #Q scl = 1;
    #(2*Q) scl = 0;
    #Q;
  endtask
  task automatic bitIn(output logic b);
    sdaDrv_n = 1;
    #Q scl = 1;
    #(2*Q) b = sda;
    scl = 0;
    #Q;
  endtask
  task automatic start;
    sdaDrv_n = 1;
    #Q scl = 1;
    #Q sdaDrv_n = 0;
    #Q scl = 0;
    #Q;
  endtask
  task automatic stop;
    sdaDrv_n = 0;
    #Q scl = 1;
    #Q sdaDrv_n = 1;
    #Q;
  endtask
  task automatic wrByte(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) bitOut(b[i]);
    bitIn(a);
  endtask
  task automatic rdByte(input logic m, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bitIn(d[i]);
    bitOut(m);
  endtask
endmodule
`default_nettype wire

// *** tb/sew_eeprom_slave_bench.sv ***
// Purpose: self-checking bench of the eeprom slave
// Assumes: 2 kbit density, straps 101
// Notes: write time shortened so polling stays quick
`timescale 1ns/1ps
`default_nettype none
module sew_eeprom_slave_bench;
  logic core_clk = 0;
  logic rst = 1;
  logic [2:0] strap = 3'h5;
  logic scl, mDrv_n, sdaOut, sdaOe_n, writeBusy, a;
  logic [7:0] d;
  wire sda = mDrv_n & (sdaOe_n | sdaOut);
  int fails = 0;
  int n_compared = 0;
  always #12.5 core_clk = ~core_clk;
  sew_master M (.scl(scl), .sdaDrv_n(mDrv_n), .sda(sda));
  sew_eeprom_slave #(.DENSITY_KBIT(2), .WR_CYCLES(400)) DUT (.core_clk(core_clk), .rst(rst), .sclIn(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .strap_pin_high(strap[2]), .strap_pin_mid(strap[1]),
    .strap_pin_low(strap[0]), .writeBusy(writeBusy));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic sendAck(input logic [7:0] b, input logic e, input string n);
    M.wrByte(b, a);
    chk(n, {7'h0, e}, {7'h0, a});
  endtask
  task automatic tSelect;
    M.start();
    sendAck(8'hBA, 1, "type");
    M.stop();
    M.start();
    sendAck(8'hA8, 1, "strap");
    M.stop();
    M.start();
    sendAck(8'hAA, 0, "match");
    M.stop();
  endtask
  task automatic tWrite;
    int k;
    M.start();
    sendAck(8'hAA, 0, "dev");
    sendAck(8'h3E, 0, "word");
    for (k = 0; k < 4; k++) sendAck(8'(k + 16), 0, "data");
    M.stop();
    // the stop needs the two sync stages and the detect before busy shows
    repeat (4) @(negedge core_clk);
    chk("busy", 8'h1, {7'h0, writeBusy});
    M.start();
    sendAck(8'hAA, 1, "busy nak");
    M.stop();
    k = 0;
    // a write-only poll loads no data, so it starts no new write
    while (a !== 1'b0 && k < 20) begin
      M.start();
      M.wrByte(8'hAA, a);
      M.stop();
      k++;
    end
    chk("poll", 8'h0, {7'h0, a});
  endtask
  task automatic rdAt(input logic [7:0] w);
    M.start();
    sendAck(8'hAA, 0, "dev");
    sendAck(w, 0, "word");
    M.start();
    sendAck(8'hAB, 0, "rdev");
  endtask
  task automatic tRead;
    rdAt(8'h38);
    M.rdByte(0, d);
    chk("wrap", 8'h12, d);
    M.rdByte(1, d);
    chk("seq", 8'h13, d);
    M.stop();
    rdAt(8'h3E);
    M.rdByte(1, d);
    chk("rnd", 8'h10, d);
    M.stop();
    M.start();
    sendAck(8'hAB, 0, "cur");
    M.rdByte(1, d);
    chk("cur", 8'h11, d);
    M.stop();
  endtask
  task automatic results;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    rst = 0;
    repeat (4) @(negedge core_clk);
    tSelect;
    tWrite;
    tRead;
    results;
  end
  initial begin
    #2000000;
    fails++;
    results;
  end
endmodule
`default_nettype wire
